// File: core/bchr_regs.sv
// Configuration header registers 0Ch..1Ch of a two-port bridge.
// Assumes host accesses arrive on a plain strobe port in the bus clock;
// the enable and mode straps are pins and are synchronised here.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RQ1 - Upper five primary latency timer bits are writable.
// RQ2 - Lower three primary latency timer bits read as zero.
// RQ3 - Header type reads single function, bridge layout code 0000001.
// RQ4 - Self-test byte always reads zero.
// RQ5 - Lower base bits 31:20 writable when window enabled, else zero.
// RQ6 - Lower base bits 19:4 reserved, read zero.
// RQ7 - Lower base bit 3 reads one, prefetchable.
// RQ8 - Lower base bits 2:1 read 10b, 64-bit decoder.
// RQ9 - Lower base bit 0 reads zero, memory decoder.
// RQ10 - Upper base word writable when window enabled, else zero.
// RQ11 - Upstream bus number writable, reset to zero.
// RQ12 - Downstream bus number writable, reset to zero.
// RQ13 - Highest bus number writable, reset to zero.
// RQ14 - Downstream latency timer writable; resets 00h, or 40h in extended mode.
// RQ15 - I/O base nibble holds address bits 15:12, writable.
// RQ16 - I/O base bits 3:2 reserved, read zero.
// RQ17 - I/O base bits 1:0 read 01b, 32-bit I/O.
// RQ18 - Writes to read-only and reserved fields have no effect.
module bchr_regs (
    input wire logic clk, // Bus clock, 200 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire logic [7:0] addr, // Byte address of the word
    input wire logic [31:0] wdata, // Write data
    input wire logic wr, // Write strobe, one cycle
    input wire logic rd, // Read strobe, one cycle
    input wire logic bar_en, // Memory base window enable strap
    input wire logic ext_mode, // Extended-protocol mode strap
    output logic [31:0] rdata, // Read data, cycle after rd
    output logic win_en // Synchronised window enable
);

    logic [1:0] en_sync_r;
    logic [1:0] mode_sync_r;
    logic mode_seen_r;
    logic [4:0] pri_lat_r;
    logic [11:0] bar_lo_r;
    logic [31:0] bar_hi_r;
    bchr_pkg::bchr_bus_s bus_r;
    logic [3:0] io_base_r;
    logic [31:0] rd_nxt;

    // Straps come from pins; only the second stage is read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_sync_r <= 2'h0;
            mode_sync_r <= 2'h0;
        end else begin
            en_sync_r <= {en_sync_r[0], bar_en};
            mode_sync_r <= {mode_sync_r[0], ext_mode};
        end
    end

    // Window enable is mirrored out for the decoder
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            win_en <= 1'b0;
        end else begin
            win_en <= en_sync_r[1];
        end
    end

    // Primary latency timer, only its writable top bits are stored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pri_lat_r <= bchr_pkg::RST_PRI_LAT;
        end else if (wr && addr == bchr_pkg::OFS_HDR_WORD) begin
            pri_lat_r <= wdata[bchr_pkg::POS_PRI_LAT +: 5]; // RQ1 RQ18
        end
    end

    // Memory base pair; writes are dropped while the window is off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bar_lo_r <= bchr_pkg::RST_BAR_LO;
            bar_hi_r <= bchr_pkg::RST_BAR_HI;
        end else if (wr && en_sync_r[1]) begin
            if (addr == bchr_pkg::OFS_BAR_LO) begin
                bar_lo_r <= wdata[bchr_pkg::POS_BAR_ADDR +: 12]; // RQ5
            end
            if (addr == bchr_pkg::OFS_BAR_HI) begin
                bar_hi_r <= wdata; // RQ10
            end
        end
    end

    // Bus numbers and downstream timer share one word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_r.upstream <= bchr_pkg::RST_BUS_NUM; // RQ11
            bus_r.downstream <= bchr_pkg::RST_BUS_NUM; // RQ12
            bus_r.highest <= bchr_pkg::RST_BUS_NUM; // RQ13
            bus_r.dn_lat <= bchr_pkg::RST_DN_LAT_CONV;
        end else if (wr && addr == bchr_pkg::OFS_BUS_WORD) begin
            bus_r <= wdata; // RQ11 RQ12 RQ13 RQ14
        end else if (!mode_seen_r && mode_sync_r[1]) begin
            // Mode strap is caught after release, not under reset
            bus_r.dn_lat <= bchr_pkg::RST_DN_LAT_EXT; // RQ14
        end
    end

    // Remembers that the mode strap or a bus word write has been seen once; a host write
    // to the bus word wins, so a late strap never overwrites software
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_seen_r <= 1'b0;
        end else if (wr && addr == bchr_pkg::OFS_BUS_WORD) begin
            mode_seen_r <= 1'b1;
        end else if (mode_sync_r[1]) begin
            mode_seen_r <= 1'b1;
        end
    end

    // I/O base nibble; low bits are constants
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            io_base_r <= bchr_pkg::RST_IO_BASE;
        end else if (wr && addr == bchr_pkg::OFS_IO_WORD) begin
            io_base_r <= wdata[bchr_pkg::POS_IO_BASE +: 4]; // RQ15 RQ18
        end
    end

    // Read mux; bytes outside this slice read zero
    always_comb begin
        rd_nxt = 32'h00000000;
        case (addr)
            bchr_pkg::OFS_HDR_WORD: begin
                rd_nxt[bchr_pkg::POS_PRI_LAT +: 5] = pri_lat_r; // RQ1
                rd_nxt[10:8] = bchr_pkg::PRI_LAT_LOW; // RQ2
                rd_nxt[bchr_pkg::POS_HDR_TYPE +: 8] = bchr_pkg::HDR_TYPE_VAL; // RQ3
                rd_nxt[bchr_pkg::POS_SELF_TEST +: 8] = bchr_pkg::SELF_TEST_VAL; // RQ4
            end
            bchr_pkg::OFS_BAR_LO: begin
                if (en_sync_r[1]) begin
                    rd_nxt[bchr_pkg::POS_BAR_ADDR +: 12] = bar_lo_r; // RQ5
                end
                rd_nxt[3:0] = bchr_pkg::BAR_LO_ATTR; // RQ6 RQ7 RQ8 RQ9
            end
            bchr_pkg::OFS_BAR_HI: begin
                if (en_sync_r[1]) begin
                    rd_nxt = bar_hi_r; // RQ10
                end
            end
            bchr_pkg::OFS_BUS_WORD: begin
                rd_nxt = bus_r;
            end
            bchr_pkg::OFS_IO_WORD: begin
                rd_nxt[bchr_pkg::POS_IO_BASE +: 4] = io_base_r; // RQ15
                rd_nxt[3:0] = bchr_pkg::IO_BASE_LOW; // RQ16 RQ17
            end
            default: begin
                rd_nxt = 32'h00000000;
            end
        endcase
    end

    // Read data stand for exactly the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            rdata <= rd_nxt;
        end else begin
            rdata <= 32'h00000000;
        end
    end

    // Access steps used by the checks below
    sequence s_rd_hdr;
        rd && addr == bchr_pkg::OFS_HDR_WORD;
    endsequence

    sequence s_wr_hdr;
        wr && addr == bchr_pkg::OFS_HDR_WORD;
    endsequence

    sequence s_rd_bar_lo;
        rd && addr == bchr_pkg::OFS_BAR_LO;
    endsequence

    sequence s_rd_bar_hi;
        rd && addr == bchr_pkg::OFS_BAR_HI;
    endsequence

    sequence s_wr_bus;
        wr && addr == bchr_pkg::OFS_BUS_WORD;
    endsequence

    sequence s_rd_bus;
        rd && addr == bchr_pkg::OFS_BUS_WORD;
    endsequence

    sequence s_wr_io;
        wr && addr == bchr_pkg::OFS_IO_WORD;
    endsequence

    sequence s_rd_io;
        rd && addr == bchr_pkg::OFS_IO_WORD;
    endsequence

    // Self-test byte is never anything but zero
    chk_self_test_zero: assert property (@(posedge clk) disable iff (rst) // RQ4
        s_rd_hdr |=> rdata[31:24] == 8'h00)
        else $error("self-test byte not zero");

    // Single function bridge layout code
    chk_hdr_type_code: assert property (@(posedge clk) disable iff (rst) // RQ3
        s_rd_hdr |=> rdata[23:16] == 8'h01)
        else $error("header type code wrong");

    // Stored latency bits come back in place
    chk_lat_read: assert property (@(posedge clk) disable iff (rst) // RQ1
        s_rd_hdr |=> rdata[15:11] == $past(pri_lat_r))
        else $error("latency readback wrong");

    // Without a header write the timer must hold
    chk_lat_keep: assert property (@(posedge clk) disable iff (rst) // RQ18
        !(wr && addr == bchr_pkg::OFS_HDR_WORD) |=> pri_lat_r == $past(pri_lat_r))
        else $error("latency changed without write");

    // Enabled window takes the written base bits
    chk_bar_lo_write: assert property (@(posedge clk) disable iff (rst) // RQ5
        wr && addr == bchr_pkg::OFS_BAR_LO && en_sync_r[1]
        |=> bar_lo_r == $past(wdata[31:20]))
        else $error("lower base write lost");

    // Disabled window drops writes, value kept for later
    chk_bar_lo_drop: assert property (@(posedge clk) disable iff (rst) // RQ5
        wr && addr == bchr_pkg::OFS_BAR_LO && !en_sync_r[1]
        |=> bar_lo_r == $past(bar_lo_r))
        else $error("lower base written while off");

    chk_bar_hi_write: assert property (@(posedge clk) disable iff (rst) // RQ10
        wr && addr == bchr_pkg::OFS_BAR_HI && en_sync_r[1]
        |=> bar_hi_r == $past(wdata))
        else $error("upper base write lost");

    chk_bar_hi_drop: assert property (@(posedge clk) disable iff (rst) // RQ10
        wr && addr == bchr_pkg::OFS_BAR_HI && !en_sync_r[1]
        |=> bar_hi_r == $past(bar_hi_r))
        else $error("upper base written while off");

    // Enabled window shows the stored base
    chk_bar_lo_read: assert property (@(posedge clk) disable iff (rst) // RQ5
        rd && addr == bchr_pkg::OFS_BAR_LO && en_sync_r[1]
        |=> rdata[31:20] == $past(bar_lo_r))
        else $error("lower base readback wrong");

    chk_bar_hi_read: assert property (@(posedge clk) disable iff (rst) // RQ10
        rd && addr == bchr_pkg::OFS_BAR_HI && en_sync_r[1]
        |=> rdata == $past(bar_hi_r))
        else $error("upper base readback wrong");

    // Attribute bits of the lower base, one check per field
    chk_bar_reserved: assert property (@(posedge clk) disable iff (rst) // RQ6
        s_rd_bar_lo |=> rdata[19:4] == 16'h0000)
        else $error("lower base reserved bits set");

    chk_bar_prefetch: assert property (@(posedge clk) disable iff (rst) // RQ7
        s_rd_bar_lo |=> rdata[3] == 1'b1)
        else $error("prefetch bit not set");

    chk_bar_width: assert property (@(posedge clk) disable iff (rst) // RQ8
        s_rd_bar_lo |=> rdata[2:1] == 2'h2)
        else $error("decoder width code wrong");

    chk_bar_mem: assert property (@(posedge clk) disable iff (rst) // RQ9
        s_rd_bar_lo |=> rdata[0] == 1'b0)
        else $error("decoder type bit set");

    // Upper half never leaks through a disabled window
    chk_bar_hi_quiet: assert property (@(posedge clk) disable iff (rst) // RQ10
        s_rd_bar_hi ##0 !en_sync_r[1] |=> rdata == 32'h00000000)
        else $error("upper base leaks while off");

    // Upstream, highest and timer bytes of the bus word are taken from the write
    chk_up_bus_write: assert property (@(posedge clk) disable iff (rst) // RQ11
        s_wr_bus |=> bus_r.upstream == $past(wdata[7:0]))
        else $error("upstream bus write lost");

    chk_hi_bus_write: assert property (@(posedge clk) disable iff (rst) // RQ13
        s_wr_bus |=> bus_r.highest == $past(wdata[23:16]))
        else $error("highest bus write lost");

    chk_dn_lat_write: assert property (@(posedge clk) disable iff (rst) // RQ14
        s_wr_bus |=> bus_r.dn_lat == $past(wdata[31:24]))
        else $error("downstream timer write lost");

    chk_bus_read: assert property (@(posedge clk) disable iff (rst) // RQ11
        s_rd_bus |=> rdata == $past(bus_r))
        else $error("bus word readback wrong");

    // Extended mode loads its timer value once after release
    chk_dn_lat_ext: assert property (@(posedge clk) disable iff (rst) // RQ14
        !mode_seen_r && mode_sync_r[1] && !(wr && addr == bchr_pkg::OFS_BUS_WORD)
        |=> bus_r.dn_lat == 8'h40)
        else $error("extended timer value missing");

    // I/O base nibble and its fixed low bits
    chk_io_write: assert property (@(posedge clk) disable iff (rst) // RQ15
        s_wr_io |=> io_base_r == $past(wdata[7:4]))
        else $error("io base write lost");

    chk_io_read: assert property (@(posedge clk) disable iff (rst) // RQ15
        s_rd_io |=> rdata[7:4] == $past(io_base_r))
        else $error("io base readback wrong");

    chk_io_reserved: assert property (@(posedge clk) disable iff (rst) // RQ16
        s_rd_io |=> rdata[3:2] == 2'h0)
        else $error("io base reserved bits set");

    // Mirrored enable trails the synchroniser by one flop
    chk_win_en_pipe: assert property (@(posedge clk) disable iff (rst) // RQ5
        1'b1 |=> win_en == $past(en_sync_r[1]))
        else $error("window enable mirror wrong");

    // Words outside this slice read zero
    chk_unmapped_zero: assert property (@(posedge clk) disable iff (rst) // RQ18
        rd && addr != bchr_pkg::OFS_HDR_WORD && addr != bchr_pkg::OFS_BAR_LO
        && addr != bchr_pkg::OFS_BAR_HI && addr != bchr_pkg::OFS_BUS_WORD
        && addr != bchr_pkg::OFS_IO_WORD |=> rdata == 32'h00000000)
        else $error("unmapped word not zero");

    chk_hdr_consts: assert property (@(posedge clk) disable iff (rst) // RQ2
        s_rd_hdr |=> rdata[10:8] == 3'h0 && rdata[31:16] == 16'h0001)
        else $error("header word constants wrong");

    chk_lat_write: assert property (@(posedge clk) disable iff (rst) // RQ1
        wr && addr == bchr_pkg::OFS_HDR_WORD |=> pri_lat_r == $past(wdata[15:11]))
        else $error("latency write lost");

    chk_bar_lo_attr: assert property (@(posedge clk) disable iff (rst) // RQ7
        rd && addr == bchr_pkg::OFS_BAR_LO |=> rdata[19:0] == 20'h0000C)
        else $error("lower base low bits wrong");

    chk_bar_gate: assert property (@(posedge clk) disable iff (rst) // RQ5
        rd && addr == bchr_pkg::OFS_BAR_LO && !en_sync_r[1] |=> rdata[31:20] == 12'h000)
        else $error("lower base visible while off");

    chk_bar_hi_gate: assert property (@(posedge clk) disable iff (rst) // RQ10
        rd && addr == bchr_pkg::OFS_BAR_HI && !en_sync_r[1] |=> rdata == 32'h0)
        else $error("upper base visible while off");

    chk_bus_write: assert property (@(posedge clk) disable iff (rst) // RQ12
        s_wr_bus ##1 !wr ##1 s_rd_bus |=> rdata == $past(wdata, 3))
        else $error("bus word readback wrong");

    chk_io_low: assert property (@(posedge clk) disable iff (rst) // RQ17
        rd && addr == bchr_pkg::OFS_IO_WORD |=> rdata[3:0] == 4'h1 && rdata[31:8] == 24'h0)
        else $error("io base low bits wrong");

    chk_rdata_idle: assert property (@(posedge clk) disable iff (rst) // RQ18
        !rd |=> rdata == 32'h0)
        else $error("read data held too long");

endmodule // bchr_regs

`default_nettype wire

// File: core/bchr_pkg.sv
// Package for the bridge configuration header register slice.
// Assumes a single bus clock domain and a plain address/strobe port.
package bchr_pkg;

    // Byte offsets of the 32-bit words that this slice answers
    localparam logic [7:0] OFS_HDR_WORD = 8'h0C;
    localparam logic [7:0] OFS_BAR_LO = 8'h10;
    localparam logic [7:0] OFS_BAR_HI = 8'h14;
    localparam logic [7:0] OFS_BUS_WORD = 8'h18;
    localparam logic [7:0] OFS_IO_WORD = 8'h1C;

    // Field positions, expressed as the low bit of each field
    localparam int POS_PRI_LAT = 11;
    localparam int POS_HDR_TYPE = 16;
    localparam int POS_SELF_TEST = 24;
    localparam int POS_BAR_ADDR = 20;
    localparam int POS_UP_BUS = 0;
    localparam int POS_DN_BUS = 8;
    localparam int POS_HI_BUS = 16;
    localparam int POS_DN_LAT = 24;
    localparam int POS_IO_BASE = 4;

    // Constant read values
    localparam logic [2:0] PRI_LAT_LOW = 3'h0;
    localparam logic [7:0] HDR_TYPE_VAL = 8'h01;
    localparam logic [7:0] SELF_TEST_VAL = 8'h00;
    localparam logic [3:0] BAR_LO_ATTR = 4'hC;
    localparam logic [3:0] IO_BASE_LOW = 4'h1;

    // Reset values
    localparam logic [4:0] RST_PRI_LAT = 5'h00;
    localparam logic [11:0] RST_BAR_LO = 12'h000;
    localparam logic [31:0] RST_BAR_HI = 32'h00000000;
    localparam logic [7:0] RST_BUS_NUM = 8'h00;
    localparam logic [7:0] RST_DN_LAT_CONV = 8'h00;
    localparam logic [7:0] RST_DN_LAT_EXT = 8'h40;
    localparam logic [3:0] RST_IO_BASE = 4'h0;

    // Bus numbers and downstream timer grouped as they are stored
    typedef struct packed {
        logic [7:0] dn_lat;
        logic [7:0] highest;
        logic [7:0] downstream;
        logic [7:0] upstream;
    } bchr_bus_s;

endpackage : bchr_pkg

// File: bench/bchr_host.sv
// Host model: issues configuration word writes and reads.
// Assumes the block answers a read in the cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module bchr_host (
    input wire logic clk, // Bus clock
    output logic [7:0] addr, // Word byte address
    output logic [31:0] wdata, // Write data
    output logic wr, // Write strobe
    output logic rd, // Read strobe
    input wire logic [31:0] rdata // Read data
);
    // Idle bus from time zero
    initial begin
        addr = 8'h00;
        wdata = 32'h00000000;
        wr = 1'b0;
        rd = 1'b0;
    end

    // One-cycle strobe; address and data held through the sampling edge
    task automatic put(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe, so sample just then
    task automatic get(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
endmodule // bchr_host
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the header register slice.
// Assumes bchr_host drives the strobe port; straps are driven here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, rst, bar_en, ext_mode, win_en, en, wr, rd;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, got, m_bhi, m_bus;
    logic [11:0] m_blo;
    logic [4:0] m_lat;
    logic [3:0] m_io;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [7:0] amap [7] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h08, 8'h20};

    bchr_regs dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .bar_en(bar_en), .ext_mode(ext_mode),
        .rdata(rdata), .win_en(win_en));
    bchr_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata));

    // Expected word, built from the model fields
    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        case (a)
            8'h0C: return {16'h0001, m_lat, 11'h000};
            8'h10: return {en ? m_blo : 12'h000, 20'h0000C};
            8'h14: return en ? m_bhi : 32'h00000000;
            8'h18: return m_bus;
            8'h1C: return {24'h000000, m_io, 4'h1};
            default: return 32'h00000000;
        endcase
    endfunction

    task automatic chk(input string n, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // Writes to the base pair while disabled are dropped, value kept
    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d);
        host.put(a, d);
        if (a == 8'h0C) m_lat = d[15:11];
        if (a == 8'h10 && en) m_blo = d[31:20];
        if (a == 8'h14 && en) m_bhi = d;
        if (a == 8'h18) m_bus = d;
        if (a == 8'h1C) m_io = d[7:4];
    endtask

    task automatic rd_chk(input logic [7:0] a);
        host.get(a, got);
        chk($sformatf("word %h", a), exp_rd(a), got);
    endtask

    // Margin after release lets the mode strap pass its synchroniser
    task automatic do_reset(input logic ext);
        @(posedge clk);
        rst <= 1'b1;
        ext_mode <= ext;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        {m_lat, m_blo, m_bhi, m_io} = '0;
        m_bus = ext ? 32'h40000000 : 32'h00000000;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Whole run needs well under this many cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            stop_test();
        end
    end

    initial begin
        logic [31:0] d;
        rst = 1'b1;
        bar_en = 1'b1;
        ext_mode = 1'b1;
        en = 1'b1;
        void'($urandom(32'hEA1E));
        do_reset(1'b1);
        foreach (amap[i]) rd_chk(amap[i]);
        $display("test reset values done");
        for (int k = 0; k < 6; k++) begin
            d = (k == 0) ? 32'hFFFFFFFF : $urandom();
            foreach (amap[i]) wr_chk(amap[i], d ^ {24'h0, amap[i]});
            foreach (amap[i]) rd_chk(amap[i]);
        end
        $display("test write readback done");
        bar_en <= 1'b0;
        repeat (5) @(posedge clk);
        en = 1'b0;
        chk("win_en", 32'h0, {31'h0, win_en});
        wr_chk(8'h10, $urandom());
        wr_chk(8'h14, $urandom());
        rd_chk(8'h10);
        rd_chk(8'h14);
        bar_en <= 1'b1;
        repeat (5) @(posedge clk);
        en = 1'b1;
        chk("win_en", 32'h1, {31'h0, win_en});
        rd_chk(8'h10);
        rd_chk(8'h14);
        $display("test window strap done");
        do_reset(1'b0);
        foreach (amap[i]) rd_chk(amap[i]);
        $display("test conventional reset done");
        stop_test();
    end
endmodule // testbench
`default_nettype wire
